/* logic/dias_defs.svh */
// Constants for the dual incremental converter sequencer
`ifndef DIAS_DEFS_SVH
`define DIAS_DEFS_SVH

`define DIAS_RES_MIN       4'h7
`define DIAS_RES_MAX       4'hd
`define DIAS_EXTRA_BITS    2
`define DIAS_HW_LOAD       8'hff
`define DIAS_UPPER_LOAD    8'hff
`define DIAS_CALC_MIN      16'h0001
`define DIAS_TMR_START     16'h0001
`define DIAS_ST_READY_BIT  7
`define DIAS_ST_RUN_BIT    0
`define DIAS_PH1_SLOT      2'h0
`define DIAS_PH2_SLOT      2'h2
`define DIAS_PH_STEP       2'h1

`endif

/* logic/dias_pkg.sv */
// Types shared by the dual incremental converter sequencer
package dias_pkg;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_RUN
   } dias_state_t;

   typedef struct packed {
      logic [3:0]  resBits;
      logic        twosComp;
      logic [15:0] calcInterval;
   } dias_cfg_t;

   typedef struct packed {
      logic [15:0] ch2;
      logic [15:0] ch1;
   } dias_result_t;

endpackage

/* logic/dias_chan_cnt.sv */
// One channel: 8-bit hardware counter plus upper count extension
`timescale 1ns/1ps
`include "dias_defs.svh"

module dias_chan_cnt #(
   parameter int HW_W    = 8,
   parameter int UPPER_W = 8
) (
   input  wire logic                      clk,
   input  wire logic                      rstn,
   input  wire logic                      load,
   input  wire logic                      countEn,
   output logic      [HW_W-1:0]           hwCount,
   output logic                           ovfPulse,
   output logic      [HW_W+UPPER_W-1:0]   total
);

   logic [HW_W-1:0]    hw_ff;
   logic [HW_W-1:0]    nxt_hw;
   logic [UPPER_W-1:0] upper_ff;
   logic [UPPER_W-1:0] nxt_upper;
   logic               ovf_ff;
   logic               nxt_ovf;

   always_comb begin
      nxt_hw    = hw_ff;
      nxt_upper = upper_ff;
      nxt_ovf   = 1'b0;
      if (load) begin
         nxt_hw    = `DIAS_HW_LOAD;
         nxt_upper = `DIAS_UPPER_LOAD;
      end else if (countEn) begin
         nxt_hw = hw_ff + 1'b1;
         if (hw_ff == {HW_W{1'b1}}) begin
            nxt_ovf   = 1'b1;
            nxt_upper = upper_ff + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         hw_ff    <= `DIAS_HW_LOAD;
         upper_ff <= `DIAS_UPPER_LOAD;
         ovf_ff   <= 1'b0;
      end else begin
         hw_ff    <= nxt_hw;
         upper_ff <= nxt_upper;
         ovf_ff   <= nxt_ovf;
      end
   end

   // Load values make the sum read minus one, so adding one gives the positives seen
   assign hwCount  = hw_ff;
   assign ovfPulse = ovf_ff;
   assign total    = {upper_ff, hw_ff} + {{(HW_W+UPPER_W-1){1'b0}}, 1'b1};

endmodule // dias_chan_cnt

/* logic/dias_adc_seq.sv */
// Sequencer for a two-channel incremental converter with a shared window timer
`timescale 1ns/1ps
`include "dias_defs.svh"

// Summary of operation
// - One shared 16-bit timer serves both channels
// - Resolution 7 to 13, two's complement or unsigned
// - Code counts positive decisions over 2^Bits operations
// - Each channel has an 8-bit positive counter
// - Timer window gates counting into both counters
// - Phase clocks run at quarter rate
// - Everything runs from one conversion clock
// - Counter overflow interrupts; upper count extends by one
// - Conversion lasts window plus calculation interval
// - Output high 2^(Bits+2), then low interval
// - Low phase computes results, resets integrators
// - Start loads FFh, first window delayed
// - Count at or below compare drives output high
// - Window end stops counters, raises end interrupt
// - Counters follow comparator, every edge at full scale
// - Status MSB marks a fresh result pair
// - Out-of-range inputs clamp to extreme codes
module dias_adc_seq #(
   parameter int TMR_W   = 16,
   parameter int HW_W    = 8,
   parameter int UPPER_W = 8,
   parameter int N_CH    = 2
) (
   input  wire logic                       clk,
   input  wire logic                       rstn,
   input  wire dias_pkg::dias_cfg_t        cfg,
   input  wire logic                       startReading,
   input  wire logic                       stopReading,
   input  wire logic                       resultAck,
   input  wire logic      [N_CH-1:0]       compPin,
   output logic                            phaseClk1,
   output logic                            phaseClk2,
   output logic                            integWindow,
   output logic                            integReset,
   output logic                            endIntegIrq,
   output logic           [N_CH-1:0]       cntOvfIrq,
   output logic           [7:0]            statusFlags,
   output dias_pkg::dias_result_t          results
);

   localparam int SUM_W = HW_W + UPPER_W;

   // Clamp the resolution into the supported range
   function automatic logic [3:0] clampRes(input logic [3:0] r);
      if (r < `DIAS_RES_MIN) begin
         clampRes = `DIAS_RES_MIN;
      end else if (r > `DIAS_RES_MAX) begin
         clampRes = `DIAS_RES_MAX;
      end else begin
         clampRes = r;
      end
   endfunction

   // Turn an accumulated count into the output code
   function automatic logic [15:0] makeCode(input logic [SUM_W-1:0] sum,
                                            input logic [3:0]       bits,
                                            input logic             twos);
      logic [SUM_W-1:0] n;
      logic [15:0]      maxCode;
      logic [15:0]      half;
      logic [15:0]      code;
      n       = sum >> `DIAS_EXTRA_BITS;
      maxCode = 16'((32'h1 << bits) - 32'h1);
      half    = 16'(32'h1 << (bits - 4'h1));
      code    = 16'(n);
      if (code > maxCode) begin
         code = maxCode;
      end
      if (twos) begin
         code = code - half;
      end
      makeCode = code;
   endfunction

   // Comparator pins come from the analog side: two flip-flops first
   logic [N_CH-1:0] compMeta_ff;
   logic [N_CH-1:0] compSync_ff;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         compMeta_ff <= '0;
         compSync_ff <= '0;
      end else begin
         compMeta_ff <= compPin;
         compSync_ff <= compMeta_ff;
      end
   end

   // Sequencer state and shared timer
   dias_pkg::dias_state_t state_ff;
   dias_pkg::dias_state_t nxt_state;
   dias_pkg::dias_cfg_t   cfg_ff;
   dias_pkg::dias_cfg_t   nxt_cfg;
   logic [TMR_W-1:0]      tmr_ff;
   logic [TMR_W-1:0]      nxt_tmr;
   logic                  seenWin_ff;
   logic                  nxt_seenWin;
   logic                  endIrq_ff;
   logic                  nxt_endIrq;
   logic [TMR_W-1:0]      integLen;
   logic [TMR_W-1:0]      calcLen;
   logic [TMR_W-1:0]      period;
   logic                  running;
   logic                  winActive;
   logic                  lastLow;
   logic                  firstLow;
   logic [3:0]            effBits;

   assign effBits   = clampRes(cfg_ff.resBits);
   assign integLen  = TMR_W'(32'h1 << (effBits + `DIAS_EXTRA_BITS));
   assign calcLen   = (cfg_ff.calcInterval < `DIAS_CALC_MIN) ?
                      `DIAS_CALC_MIN : cfg_ff.calcInterval;
   assign period    = integLen + calcLen;
   assign running   = (state_ff == dias_pkg::ST_RUN);
   assign winActive = running && (tmr_ff <= integLen);
   assign lastLow   = running && (tmr_ff == period);
   assign firstLow  = running && (tmr_ff == integLen + `DIAS_TMR_START);

   always_comb begin
      nxt_state   = state_ff;
      nxt_cfg     = cfg_ff;
      nxt_tmr     = tmr_ff;
      nxt_seenWin = seenWin_ff;
      nxt_endIrq  = 1'b0;
      unique case (state_ff)
         dias_pkg::ST_IDLE: begin
            if (startReading) begin
               // Settings are captured once; the first window waits a full interval
               nxt_cfg     = cfg;
               nxt_state   = dias_pkg::ST_RUN;
               nxt_tmr     = TMR_W'(32'h1 << (clampRes(cfg.resBits) + `DIAS_EXTRA_BITS))
                             + `DIAS_TMR_START;
               nxt_seenWin = 1'b0;
            end
         end
         dias_pkg::ST_RUN: begin
            if (stopReading) begin
               nxt_state = dias_pkg::ST_IDLE;
               nxt_tmr   = '0;
            end else begin
               if (lastLow) begin
                  nxt_tmr = `DIAS_TMR_START;
               end else begin
                  nxt_tmr = tmr_ff + `DIAS_TMR_START;
               end
               if (tmr_ff == integLen) begin
                  nxt_endIrq  = 1'b1;
                  nxt_seenWin = 1'b1;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_ff   <= dias_pkg::ST_IDLE;
         cfg_ff     <= '0;
         tmr_ff     <= '0;
         seenWin_ff <= 1'b0;
         endIrq_ff  <= 1'b0;
      end else begin
         state_ff   <= nxt_state;
         cfg_ff     <= nxt_cfg;
         tmr_ff     <= nxt_tmr;
         seenWin_ff <= nxt_seenWin;
         endIrq_ff  <= nxt_endIrq;
      end
   end

   // Quarter-rate non-overlapping phase clocks from the same clock
   logic [1:0] phDiv_ff;
   logic [1:0] nxt_phDiv;
   logic       ph1_ff;
   logic       nxt_ph1;
   logic       ph2_ff;
   logic       nxt_ph2;

   always_comb begin
      nxt_phDiv = phDiv_ff + `DIAS_PH_STEP;
      nxt_ph1   = (nxt_phDiv == `DIAS_PH1_SLOT);
      nxt_ph2   = (nxt_phDiv == `DIAS_PH2_SLOT);
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         phDiv_ff <= '0;
         ph1_ff   <= 1'b0;
         ph2_ff   <= 1'b0;
      end else begin
         phDiv_ff <= nxt_phDiv;
         ph1_ff   <= nxt_ph1;
         ph2_ff   <= nxt_ph2;
      end
   end

   // Channel counters, gated by the shared window
   logic [N_CH-1:0]            chLoad;
   logic [N_CH-1:0]            chCountEn;
   logic [N_CH-1:0][SUM_W-1:0] chTotal;

   genvar ch;
   generate
      for (ch = 0; ch < N_CH; ch = ch + 1) begin : gChan
         assign chLoad[ch]    = (state_ff == dias_pkg::ST_IDLE && startReading)
                                || (lastLow && !stopReading);
         assign chCountEn[ch] = winActive && compSync_ff[ch];
         dias_chan_cnt #(
            .HW_W    (HW_W),
            .UPPER_W (UPPER_W)
         ) uChan (
            .clk      (clk),
            .rstn     (rstn),
            .load     (chLoad[ch]),
            .countEn  (chCountEn[ch]),
            .hwCount  (),
            .ovfPulse (cntOvfIrq[ch]),
            .total    (chTotal[ch])
         );
      end
   endgenerate

   // Result capture and status flags
   dias_pkg::dias_result_t res_ff;
   dias_pkg::dias_result_t nxt_res;
   logic                   ready_ff;
   logic                   nxt_ready;
   logic                   capture;

   assign capture = firstLow && seenWin_ff;

   always_comb begin
      nxt_res   = res_ff;
      nxt_ready = ready_ff;
      if (resultAck) begin
         nxt_ready = 1'b0;
      end
      if (capture) begin
         // Both channels are latched together; a set beats a simultaneous clear
         nxt_res.ch1 = makeCode(chTotal[0], effBits, cfg_ff.twosComp);
         nxt_res.ch2 = makeCode(chTotal[1], effBits, cfg_ff.twosComp);
         nxt_ready   = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         res_ff   <= '0;
         ready_ff <= 1'b0;
      end else begin
         res_ff   <= nxt_res;
         ready_ff <= nxt_ready;
      end
   end

   always_comb begin
      statusFlags                     = 8'h00;
      statusFlags[`DIAS_ST_READY_BIT] = ready_ff;
      statusFlags[`DIAS_ST_RUN_BIT]   = running;
   end

   assign phaseClk1   = ph1_ff;
   assign phaseClk2   = ph2_ff;
   assign integWindow = winActive;
   assign integReset  = !winActive;
   assign endIntegIrq = endIrq_ff;
   assign results     = res_ff;

endmodule // dias_adc_seq

/* sim/dias_seq_props.sv */
// Checker of sequencing relations at the converter sequencer ports
`timescale 1ns/1ps
module dias_seq_props #(parameter int N_CH = 2) (
   input wire logic                   clk,
   input wire logic                   rstn,
   input wire logic                   resultAck,
   input wire logic                   phaseClk1,
   input wire logic                   phaseClk2,
   input wire logic                   integWindow,
   input wire logic                   integReset,
   input wire logic                   endIntegIrq,
   input wire logic [N_CH-1:0]        cntOvfIrq,
   input wire logic [7:0]             statusFlags,
   input wire dias_pkg::dias_result_t results
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   win_reset_a: assert property (integReset == !integWindow)
      else $error("integrator reset not inverse of window");
   end_irq_a: assert property ($fell(integWindow) && statusFlags[0] |-> endIntegIrq)
      else $error("no end interrupt at window close");
   irq_cause_a: assert property (endIntegIrq |-> !integWindow && $past(integWindow))
      else $error("end interrupt without window close");
   ready_set_a: assert property (endIntegIrq && statusFlags[0] |=> statusFlags[7])
      else $error("ready flag not set after window");
   ready_clear_a: assert property (resultAck && !endIntegIrq |=> !statusFlags[7])
      else $error("ready flag not cleared by ack");
   phase_quarter_a: assert property (phaseClk1 |=> !phaseClk1 [*3] ##1 phaseClk1)
      else $error("phase clock not at quarter rate");
   phase_offset_a: assert property (phaseClk1 |-> ##2 phaseClk2)
      else $error("phase clocks not offset by two");
   count_gate_a: assert property (|cntOvfIrq |-> $past(integWindow))
      else $error("overflow outside the window");
   window_run_a: assert property (integWindow |-> statusFlags[0])
      else $error("window open while idle");
   result_hold_a: assert property (!endIntegIrq |=> $stable(results))
      else $error("results changed without capture");
endmodule // dias_seq_props

bind dias_adc_seq dias_seq_props #(.N_CH(N_CH)) i_dias_seq_props (
   .clk(clk), .rstn(rstn), .resultAck(resultAck), .phaseClk1(phaseClk1),
   .phaseClk2(phaseClk2), .integWindow(integWindow), .integReset(integReset),
   .endIntegIrq(endIntegIrq), .cntOvfIrq(cntOvfIrq), .statusFlags(statusFlags),
   .results(results));

/* sim/dias_host_model.sv */
// Host firmware model: extends counts on overflow, acknowledges results
`timescale 1ns/1ps
module dias_host_model (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic [1:0] cntOvfIrq,
   input  wire logic       endIntegIrq,
   input  wire logic [7:0] statusFlags,
   input  wire logic [7:0] ackDelay,
   output logic            resultAck,
   output int              ovfCnt [2]
);
   int run [2];
   int waited;
   always @(posedge clk) begin
      resultAck <= 1'b0;
      for (int i = 0; i < 2; i++) begin
         if (!rstn || !statusFlags[0]) run[i] <= 0;
         else if (endIntegIrq) begin
            ovfCnt[i] <= run[i] + cntOvfIrq[i];
            run[i] <= 0;
         end else run[i] <= run[i] + cntOvfIrq[i];
      end
      // Slow or prompt acknowledge, as the bench sets
      if (!rstn || !statusFlags[7] || resultAck) waited <= 0;
      else if (waited >= ackDelay) begin
         resultAck <= 1'b1;
         waited <= 0;
      end else waited <= waited + 1;
   end
endmodule // dias_host_model

/* sim/testbench.sv */
// Self-checking bench for the dual converter sequencer
`timescale 1ns/1ps
module testbench;
   logic                   clk, rstn, startReading, stopReading, resultAck;
   logic                   phaseClk1, phaseClk2, integWindow, integReset, endIntegIrq;
   logic [1:0]             cntOvfIrq;
   logic [1:0]             compPin = 2'h0;
   logic [7:0]             statusFlags, ackDelay;
   dias_pkg::dias_cfg_t    cfg;
   dias_pkg::dias_result_t results;
   int                     ovfCnt [2];
   int                     mismatches, checked, kA, kB, wpos, lowSeen;
   logic [31:0]            seed = 32'h00017f38;

   dias_adc_seq i_dias_adc_seq (.clk(clk), .rstn(rstn), .cfg(cfg),
      .startReading(startReading), .stopReading(stopReading), .resultAck(resultAck),
      .compPin(compPin), .phaseClk1(phaseClk1), .phaseClk2(phaseClk2),
      .integWindow(integWindow), .integReset(integReset), .endIntegIrq(endIntegIrq),
      .cntOvfIrq(cntOvfIrq), .statusFlags(statusFlags), .results(results));
   dias_host_model i_dias_host_model (.clk(clk), .rstn(rstn), .cntOvfIrq(cntOvfIrq),
      .endIntegIrq(endIntegIrq), .statusFlags(statusFlags), .ackDelay(ackDelay),
      .resultAck(resultAck), .ovfCnt(ovfCnt));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Comparator runs of k cycles sit well inside the window; above 9000 means full scale
   always @(posedge clk) begin
      wpos <= integWindow ? wpos + 1 : 0;
      compPin[0] <= kA > 9000 || (wpos >= 4 && wpos < 4 + kA);
      compPin[1] <= kB > 9000 || (wpos >= 4 && wpos < 4 + kB);
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [15:0] code(int b, int tw, int k);
      int c;
      c = k >> 2;
      if (c > (1 << b) - 1) c = (1 << b) - 1;
      if (tw) c = c - (1 << (b - 1));
      return c[15:0];
   endfunction
   function automatic int novf(int k);
      return k == 0 ? 0 : 1 + (k - 1) / 256;
   endfunction

   task automatic chk_v(string n, logic [15:0] e, logic [15:0] g);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_n(string n, int e, int g);
      checked++;
      if (g != e) begin
         mismatches++;
         $display("MISMATCH %s expected %0d seen %0d", n, e, g);
      end
   endtask
   task automatic step();
      @(posedge clk);
      #1;
   endtask
   task automatic wrap_up();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // One conversion: low phase, window, then capture one edge after the end pulse
   task automatic conv(int b, int tw, int c, int a, int d);
      int n, L;
      L = 1 << (b + 2);
      kA = a;
      kB = d;
      ackDelay <= 8'(xs() % 16);
      n = lowSeen;
      while (integWindow !== 1'b1 && n < 70000) begin
         n++;
         step();
      end
      chk_n("low phase", c, n);
      n = 0;
      while (integWindow === 1'b1 && n < 70000) begin
         n++;
         step();
      end
      chk_n("window", L, n);
      chk_v("end irq", 16'h0001, endIntegIrq);
      step();
      chk_v("ready", 16'h0001, statusFlags[7]);
      chk_v("ch1", code(b, tw, a > 9000 ? L : a), results.ch1);
      chk_v("ch2", code(b, tw, d > 9000 ? L : d), results.ch2);
      chk_n("ovf1", novf(a > 9000 ? L : a), ovfCnt[0]);
      chk_n("ovf2", novf(d > 9000 ? L : d), ovfCnt[1]);
      lowSeen = 1;
   endtask

   initial begin
      int rb [3] = '{7, 8, 3};
      int eb [3] = '{7, 8, 7};
      int cv [3] = '{8, 0, 4};
      int ce [3] = '{8, 1, 4};
      int a, d;
      rstn = 1'b0;
      startReading = 1'b0;
      stopReading = 1'b0;
      cfg = '0;
      ackDelay = 8'h00;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      step();
      chk_v("flags", 16'h0000, statusFlags);
      chk_v("integ reset", 16'h0001, integReset);
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         cfg <= '{rb[i][3:0], i > 0, cv[i][15:0]};
         startReading <= 1'b1;
         @(posedge clk);
         startReading <= 1'b0;
         #1;
         chk_v("running", 16'h0001, statusFlags[0]);
         lowSeen = 0;
         for (int j = 0; j < 4; j++) begin
            a = (i == 0 && j < 2) ? 9999 : int'(xs() % 500);
            d = (i == 0 && j < 2) ? (j ? 0 : 9999) : int'(xs() % 500);
            conv(eb[i], i > 0, ce[i], a, d);
         end
         @(posedge clk);
         stopReading <= 1'b1;
         @(posedge clk);
         stopReading <= 1'b0;
         #1;
         chk_v("stopped", 16'h0000, statusFlags[0]);
         chk_v("window off", 16'h0000, integWindow);
      end
      wrap_up();
   end

   initial begin
      repeat (40000) @(posedge clk);
      mismatches++;
      wrap_up();
   end
endmodule // testbench
